// File: verilog/ssr_cfg.svh
// Address map, field positions, reset values and response codes of the status register bank.
`ifndef SSR_CFG_SVH
`define SSR_CFG_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define SSR_OFF_STATUS 8'h00
`define SSR_OFF_WDCTL 8'h04
`define SSR_OFF_WDTO 8'h08
`define SSR_OFF_WDSVC 8'h0c
`define SSR_OFF_SCRATCH0 8'h10
`define SSR_OFF_IDHI 8'h24
`define SSR_OFF_IDLO 8'h28
`define SSR_OFF_IRQSTS 8'h2c
`define SSR_OFF_IRQMSK 8'h30

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define SSR_STS_WDOG_BIT 0
`define SSR_STS_EXT_BIT 1
`define SSR_STS_POR_BIT 2
`define SSR_STS_W 3
`define SSR_WDCTL_EN_BIT 0
`define SSR_IRQ_WDOG_BIT 0
`define SSR_IRQ_ROWR_BIT 1
`define SSR_IRQ_UNMAP_BIT 2
`define SSR_IRQ_CAUSE_BIT 3
`define SSR_IRQ_W 4

// ----------------------------------------------------------------------------
// Reset values and bus codes
// ----------------------------------------------------------------------------
`define SSR_WDCTL_EN_RST 1'b0
`define SSR_WDTO_RST 16'hffff
`define SSR_IRQMSK_RST 4'h0
`define SSR_RESP_OKAY 2'b00
`define SSR_RESP_SLVERR 2'b10

`endif

// File: verilog/ssr_pkg.sv
// Types shared by the status register bank and its bus slave.
package ssr_pkg;

  typedef enum logic [3:0] {
    SEL_STATUS,
    SEL_WDCTL,
    SEL_WDTO,
    SEL_WDSVC,
    SEL_SCRATCH,
    SEL_IDHI,
    SEL_IDLO,
    SEL_IRQSTS,
    SEL_IRQMSK,
    SEL_NONE
  } ssr_reg_sel_type;

  typedef struct packed {
    logic valid;
    logic [7:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } ssr_wr_req_type;

  typedef struct packed {
    logic valid;
    logic [7:0] addr;
  } ssr_rd_req_type;

  typedef struct packed {
    logic [31:0] data;
    logic err;
  } ssr_rd_rsp_type;

endpackage

// File: verilog/ssr_sticky_bits.sv
// Sticky event bits where a set in the same cycle as a clear wins.
`timescale 1ns/10ps
`default_nettype none

module ssr_sticky_bits #(
  parameter int WIDTH = 4
) (
  input wire logic clk, // Core clock.
  input wire logic rst, // Synchronous reset, active high.
  input wire logic [WIDTH-1:0] set, // Event pulses.
  input wire logic [WIDTH-1:0] clr, // Clear pulses.
  output logic [WIDTH-1:0] q // Held bits.
);

  logic [WIDTH-1:0] q_r;
  logic [WIDTH-1:0] q_nxt;

  // The set term is ORed last so an event never falls into a clear.
  assign q_nxt = (q_r & ~clr) | set;
  assign q = q_r;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      q_r <= '0;
    end
    else
    begin
      q_r <= q_nxt;
    end
  end

endmodule

`default_nettype wire

// File: verilog/ssr_axil_slave.sv
// AXI4-Lite slave that turns bus traffic into one-cycle register requests.
`timescale 1ns/10ps
`default_nettype none
`include "ssr_cfg.svh"

module ssr_axil_slave (
  input wire logic clk, // Core clock.
  input wire logic rst, // Synchronous reset, active high.
  input wire logic [7:0] awaddr, // Write address.
  input wire logic awvalid, // Write address valid.
  output logic awready, // Write address ready.
  input wire logic [31:0] wdata, // Write data.
  input wire logic [3:0] wstrb, // Write byte strobes.
  input wire logic wvalid, // Write data valid.
  output logic wready, // Write data ready.
  output logic [1:0] bresp, // Write response.
  output logic bvalid, // Write response valid.
  input wire logic bready, // Write response ready.
  input wire logic [7:0] araddr, // Read address.
  input wire logic arvalid, // Read address valid.
  output logic arready, // Read address ready.
  output logic [31:0] rdata, // Read data.
  output logic [1:0] rresp, // Read response.
  output logic rvalid, // Read data valid.
  input wire logic rready, // Read data ready.
  output ssr_pkg::ssr_wr_req_type wr_req, // One-cycle write request.
  input wire logic wr_err, // Write hit no register.
  output ssr_pkg::ssr_rd_req_type rd_req, // One-cycle read request.
  input wire ssr_pkg::ssr_rd_rsp_type rd_rsp // Read answer, same cycle.
);

  logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic [1:0] bresp_r, rresp_r;
  logic [31:0] rdata_r, wdata_r;
  logic [7:0] awaddr_r;
  logic [3:0] wstrb_r;

  wire aw_take = awvalid & awready_r;
  wire w_take = wvalid & wready_r;
  wire b_done = bvalid_r & bready;
  wire ar_take = arvalid & arready_r;
  wire r_done = rvalid_r & rready;
  // Both halves held and no response outstanding: perform the write once.
  wire wr_fire = ~awready_r & ~wready_r & ~bvalid_r;

  assign wr_req = '{valid: wr_fire, addr: awaddr_r, data: wdata_r, strb: wstrb_r};
  assign rd_req = '{valid: ar_take, addr: araddr};
  assign awready = awready_r;
  assign wready = wready_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign arready = arready_r;
  assign rvalid = rvalid_r;
  assign rresp = rresp_r;
  assign rdata = rdata_r;

  // ----------------------------------------------------------------------------
  // Write channels
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      bvalid_r <= 1'b0;
      bresp_r <= `SSR_RESP_OKAY;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
    end
    else
    begin
      if (aw_take)
      begin
        awready_r <= 1'b0;
        awaddr_r <= awaddr;
      end
      else if (b_done)
      begin
        awready_r <= 1'b1;
      end
      if (w_take)
      begin
        wready_r <= 1'b0;
        wdata_r <= wdata;
        wstrb_r <= wstrb;
      end
      else if (b_done)
      begin
        wready_r <= 1'b1;
      end
      if (wr_fire)
      begin
        bvalid_r <= 1'b1;
        bresp_r <= wr_err ? `SSR_RESP_SLVERR : `SSR_RESP_OKAY;
      end
      else if (b_done)
      begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Read channels
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rresp_r <= `SSR_RESP_OKAY;
      rdata_r <= 32'h0000_0000;
    end
    else if (ar_take)
    begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b1;
      rdata_r <= rd_rsp.data;
      rresp_r <= rd_rsp.err ? `SSR_RESP_SLVERR : `SSR_RESP_OKAY;
    end
    else if (r_done)
    begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// File: verilog/ssr_regs.sv
// System status, scratch, identification and watchdog register bank on AXI4-Lite.
//
// Functional notes
// - Software can read and write the watchdog, external and power-on reset cause flags.
// - Five 16-bit scratch words are freely readable and writable with no side effect.
// - No reset ever clears or presets the scratch words.
// - The two identification words are read-only and writes leave them unchanged.
// - The identification words return the two 16-bit halves of the ID_CODE parameter.
// - The watchdog stays off after any reset, its enable bit reading 0.
`timescale 1ns/10ps
`default_nettype none
`include "ssr_cfg.svh"

module ssr_regs #(
  parameter int SCRATCH_COUNT = 5,
  parameter logic [31:0] ID_CODE = 32'h0a5c_3001 // Arbitrary value; tie to the scan ID.
) (
  input wire logic CORE_CLK, // Core clock, 50 MHz.
  input wire logic SYS_RST, // Synchronous reset, active high.
  input wire logic [7:0] S_AXI_AWADDR, // Write address.
  input wire logic S_AXI_AWVALID, // Write address valid.
  output logic S_AXI_AWREADY, // Write address ready.
  input wire logic [31:0] S_AXI_WDATA, // Write data.
  input wire logic [3:0] S_AXI_WSTRB, // Write byte strobes.
  input wire logic S_AXI_WVALID, // Write data valid.
  output logic S_AXI_WREADY, // Write data ready.
  output logic [1:0] S_AXI_BRESP, // Write response.
  output logic S_AXI_BVALID, // Write response valid.
  input wire logic S_AXI_BREADY, // Write response ready.
  input wire logic [7:0] S_AXI_ARADDR, // Read address.
  input wire logic S_AXI_ARVALID, // Read address valid.
  output logic S_AXI_ARREADY, // Read address ready.
  output logic [31:0] S_AXI_RDATA, // Read data.
  output logic [1:0] S_AXI_RRESP, // Read response.
  output logic S_AXI_RVALID, // Read data valid.
  input wire logic S_AXI_RREADY, // Read data ready.
  input wire logic WDOG_RST_CAUSE, // Watchdog caused the reset.
  input wire logic EXT_RST_CAUSE, // External pin caused the reset.
  input wire logic POR_RST_CAUSE, // Power-on caused the reset.
  output logic WDOG_RESET_REQ, // Watchdog expiry pulse.
  output logic IRQ // Level interrupt.
);

  localparam int IDX_W = (SCRATCH_COUNT > 1) ? $clog2(SCRATCH_COUNT) : 1;
  localparam logic [7:0] SCRATCH_END = 8'(`SSR_OFF_SCRATCH0 + 4 * SCRATCH_COUNT);

  // ----------------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------------
  function automatic ssr_pkg::ssr_reg_sel_type reg_sel(input logic [7:0] a);
    ssr_pkg::ssr_reg_sel_type s;
    s = ssr_pkg::SEL_NONE;
    if (a[1:0] == 2'b00)
    begin
      if (a == `SSR_OFF_STATUS)
        s = ssr_pkg::SEL_STATUS;
      else if (a == `SSR_OFF_WDCTL)
        s = ssr_pkg::SEL_WDCTL;
      else if (a == `SSR_OFF_WDTO)
        s = ssr_pkg::SEL_WDTO;
      else if (a == `SSR_OFF_WDSVC)
        s = ssr_pkg::SEL_WDSVC;
      else if (a >= `SSR_OFF_SCRATCH0 && a < SCRATCH_END)
        s = ssr_pkg::SEL_SCRATCH;
      else if (a == `SSR_OFF_IDHI)
        s = ssr_pkg::SEL_IDHI;
      else if (a == `SSR_OFF_IDLO)
        s = ssr_pkg::SEL_IDLO;
      else if (a == `SSR_OFF_IRQSTS)
        s = ssr_pkg::SEL_IRQSTS;
      else if (a == `SSR_OFF_IRQMSK)
        s = ssr_pkg::SEL_IRQMSK;
    end
    return s;
  endfunction

  // Byte-lane merge for the 16-bit registers; upper lanes carry nothing.
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] strb);
    logic [15:0] m;
    m = old;
    if (strb[0])
      m[7:0] = d[7:0];
    if (strb[1])
      m[15:8] = d[15:8];
    return m;
  endfunction

  // ----------------------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------------------
  ssr_pkg::ssr_wr_req_type wr;
  ssr_pkg::ssr_rd_req_type rd;
  ssr_pkg::ssr_rd_rsp_type rd_rsp;
  ssr_pkg::ssr_reg_sel_type wsel;
  ssr_pkg::ssr_reg_sel_type rsel;
  logic wr_err;

  ssr_axil_slave u_slave (
    .clk(CORE_CLK),
    .rst(SYS_RST),
    .awaddr(S_AXI_AWADDR),
    .awvalid(S_AXI_AWVALID),
    .awready(S_AXI_AWREADY),
    .wdata(S_AXI_WDATA),
    .wstrb(S_AXI_WSTRB),
    .wvalid(S_AXI_WVALID),
    .wready(S_AXI_WREADY),
    .bresp(S_AXI_BRESP),
    .bvalid(S_AXI_BVALID),
    .bready(S_AXI_BREADY),
    .araddr(S_AXI_ARADDR),
    .arvalid(S_AXI_ARVALID),
    .arready(S_AXI_ARREADY),
    .rdata(S_AXI_RDATA),
    .rresp(S_AXI_RRESP),
    .rvalid(S_AXI_RVALID),
    .rready(S_AXI_RREADY),
    .wr_req(wr),
    .wr_err(wr_err),
    .rd_req(rd),
    .rd_rsp(rd_rsp)
  );

  assign wsel = reg_sel(wr.addr);
  assign rsel = reg_sel(rd.addr);
  assign wr_err = (wsel == ssr_pkg::SEL_NONE);

  wire wr_status = wr.valid & (wsel == ssr_pkg::SEL_STATUS);
  wire wr_wdctl = wr.valid & (wsel == ssr_pkg::SEL_WDCTL);
  wire wr_wdto = wr.valid & (wsel == ssr_pkg::SEL_WDTO);
  wire wr_wdsvc = wr.valid & (wsel == ssr_pkg::SEL_WDSVC);
  wire wr_scratch = wr.valid & (wsel == ssr_pkg::SEL_SCRATCH);
  wire wr_irqmsk = wr.valid & (wsel == ssr_pkg::SEL_IRQMSK);
  wire wr_id = wr.valid & ((wsel == ssr_pkg::SEL_IDHI) | (wsel == ssr_pkg::SEL_IDLO));
  wire rd_irqsts = rd.valid & (rsel == ssr_pkg::SEL_IRQSTS);
  wire bad_access = (wr.valid & wr_err) | (rd.valid & (rsel == ssr_pkg::SEL_NONE));

  wire [7:0] wr_off = wr.addr - `SSR_OFF_SCRATCH0;
  wire [7:0] rd_off = rd.addr - `SSR_OFF_SCRATCH0;
  wire [IDX_W-1:0] wr_idx = wr_off[IDX_W+1:2];
  wire [IDX_W-1:0] rd_idx = rd_off[IDX_W+1:2];

  // ----------------------------------------------------------------------------
  // Reset cause flags
  // ----------------------------------------------------------------------------
  logic [`SSR_STS_W-1:0] sts_r;
  logic [`SSR_STS_W-1:0] sts_nxt;
  logic [`SSR_STS_W-1:0] cause;
  logic [`SSR_STS_W-1:0] sts_wr_val;

  always_comb
  begin
    cause = '0;
    cause[`SSR_STS_WDOG_BIT] = WDOG_RST_CAUSE;
    cause[`SSR_STS_EXT_BIT] = EXT_RST_CAUSE;
    cause[`SSR_STS_POR_BIT] = POR_RST_CAUSE;
  end

  assign sts_wr_val = wr_status & wr.strb[0] ? wr.data[`SSR_STS_W-1:0] : sts_r;
  // A cause seen in the cycle of a software write still lands in the flag.
  assign sts_nxt = sts_wr_val | cause;

  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
    begin
      sts_r <= cause;
    end
    else
    begin
      sts_r <= sts_nxt;
    end
  end

  // ----------------------------------------------------------------------------
  // Scratch words
  // ----------------------------------------------------------------------------
  // These hold their value across every reset, so they carry no reset branch.
  logic [15:0] scratch_r [SCRATCH_COUNT];

  genvar gi;
  generate
    for (gi = 0; gi < SCRATCH_COUNT; gi++)
    begin : g_scratch
      wire hit = wr_scratch & (wr_idx == IDX_W'(gi));
      always_ff @(posedge CORE_CLK)
      begin
        if (hit)
        begin
          scratch_r[gi] <= merge16(scratch_r[gi], wr.data, wr.strb);
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------------
  // Watchdog
  // ----------------------------------------------------------------------------
  logic wden_r;
  logic [15:0] wdto_r;
  logic [15:0] wdcnt_r;
  logic [15:0] wdcnt_nxt;
  logic wdreq_r;
  logic [15:0] wdctl_m;

  assign wdctl_m = merge16({15'h0000, wden_r}, wr.data, wr.strb);
  wire wd_expire = wden_r & (wdcnt_r == wdto_r);
  // Any write to the service word restarts the count.
  assign wdcnt_nxt = (~wden_r | wr_wdsvc | wd_expire) ? 16'h0000 : wdcnt_r + 16'h0001;

  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
    begin
      wden_r <= `SSR_WDCTL_EN_RST;
      wdto_r <= `SSR_WDTO_RST;
      wdcnt_r <= 16'h0000;
      wdreq_r <= 1'b0;
    end
    else
    begin
      if (wr_wdctl)
        wden_r <= wdctl_m[`SSR_WDCTL_EN_BIT];
      if (wr_wdto)
        wdto_r <= merge16(wdto_r, wr.data, wr.strb);
      wdcnt_r <= wdcnt_nxt;
      wdreq_r <= wd_expire;
    end
  end

  assign WDOG_RESET_REQ = wdreq_r;

  // ----------------------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------------------
  logic [`SSR_IRQ_W-1:0] irq_set;
  logic [`SSR_IRQ_W-1:0] irq_sts;
  logic [`SSR_IRQ_W-1:0] irq_msk_r;
  logic irq_r;

  always_comb
  begin
    irq_set = '0;
    irq_set[`SSR_IRQ_WDOG_BIT] = wd_expire;
    irq_set[`SSR_IRQ_ROWR_BIT] = wr_id;
    irq_set[`SSR_IRQ_UNMAP_BIT] = bad_access;
    irq_set[`SSR_IRQ_CAUSE_BIT] = |cause;
  end

  ssr_sticky_bits #(
    .WIDTH(`SSR_IRQ_W)
  ) u_irq_sts (
    .clk(CORE_CLK),
    .rst(SYS_RST),
    .set(irq_set),
    .clr({`SSR_IRQ_W{rd_irqsts}}),
    .q(irq_sts)
  );

  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
    begin
      irq_msk_r <= `SSR_IRQMSK_RST;
      irq_r <= 1'b0;
    end
    else
    begin
      if (wr_irqmsk & wr.strb[0])
        irq_msk_r <= wr.data[`SSR_IRQ_W-1:0];
      irq_r <= |(irq_sts & irq_msk_r);
    end
  end

  assign IRQ = irq_r;

  // ----------------------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------------------
  // The identification words have no write path at all.
  wire [15:0] id_hi = ID_CODE[31:16];
  wire [15:0] id_lo = ID_CODE[15:0];
  wire [15:0] scratch_rd = scratch_r[rd_idx];

  assign rd_rsp.err = (rsel == ssr_pkg::SEL_NONE);
  assign rd_rsp.data =
    (rsel == ssr_pkg::SEL_STATUS) ? {{(32-`SSR_STS_W){1'b0}}, sts_r} :
    (rsel == ssr_pkg::SEL_WDCTL) ? {31'h0000_0000, wden_r} :
    (rsel == ssr_pkg::SEL_WDTO) ? {16'h0000, wdto_r} :
    (rsel == ssr_pkg::SEL_WDSVC) ? {16'h0000, wdcnt_r} :
    (rsel == ssr_pkg::SEL_SCRATCH) ? {16'h0000, scratch_rd} :
    (rsel == ssr_pkg::SEL_IDHI) ? {16'h0000, id_hi} :
    (rsel == ssr_pkg::SEL_IDLO) ? {16'h0000, id_lo} :
    (rsel == ssr_pkg::SEL_IRQSTS) ? {{(32-`SSR_IRQ_W){1'b0}}, irq_sts} :
    (rsel == ssr_pkg::SEL_IRQMSK) ? {{(32-`SSR_IRQ_W){1'b0}}, irq_msk_r} :
    32'h0000_0000;

endmodule

`default_nettype wire

// File: tb/ssr_regs_properties.sv
// Bus timing and register content properties of the status register bank.
`timescale 1ns/10ps
`default_nettype none
`include "ssr_cfg.svh"

module ssr_regs_properties #(
  parameter logic [31:0] ID_CODE = 32'h0000_0000
) (
  input wire logic CORE_CLK, // Core clock.
  input wire logic SYS_RST, // Synchronous reset.
  input wire logic [7:0] S_AXI_AWADDR, // Write address.
  input wire logic S_AXI_AWVALID, // Write address valid.
  input wire logic S_AXI_AWREADY, // Write address ready.
  input wire logic S_AXI_WVALID, // Write data valid.
  input wire logic S_AXI_WREADY, // Write data ready.
  input wire logic [1:0] S_AXI_BRESP, // Write response.
  input wire logic S_AXI_BVALID, // Write response valid.
  input wire logic S_AXI_BREADY, // Write response ready.
  input wire logic [7:0] S_AXI_ARADDR, // Read address.
  input wire logic S_AXI_ARVALID, // Read address valid.
  input wire logic S_AXI_ARREADY, // Read address ready.
  input wire logic [31:0] S_AXI_RDATA, // Read data.
  input wire logic S_AXI_RVALID, // Read data valid.
  input wire logic S_AXI_RREADY, // Read data ready.
  input wire logic WDOG_RST_CAUSE, // Watchdog reset cause.
  input wire logic WDOG_RESET_REQ // Watchdog expiry pulse.
);
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (SYS_RST);

  // ---------------------------------------------------------------------------
  // Handshake sequences
  // ---------------------------------------------------------------------------
  sequence s_wr_taken;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
  endsequence
  sequence s_rd_taken(logic [7:0] addr);
    S_AXI_ARVALID && S_AXI_ARREADY && (S_AXI_ARADDR == addr);
  endsequence

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  a_bvalid_timing: assert property (s_wr_taken |=> !S_AXI_BVALID ##1 S_AXI_BVALID)
    else $error("write response not two cycles after the handshake");
  a_bvalid_holds: assert property (S_AXI_BVALID && !S_AXI_BREADY |=>
    S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write response dropped before it was taken");
  a_rvalid_timing: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("read data not valid right after the address handshake");
  a_rdata_holds: assert property (S_AXI_RVALID && !S_AXI_RREADY |=>
    S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read data changed before it was taken");
  a_id_high_value: assert property (s_rd_taken(`SSR_OFF_IDHI) |=>
    S_AXI_RDATA[15:0] == ID_CODE[31:16])
    else $error("high identification word wrong");
  a_id_low_value: assert property (s_rd_taken(`SSR_OFF_IDLO) |=>
    S_AXI_RDATA[15:0] == ID_CODE[15:0])
    else $error("low identification word wrong");
  a_id_write_okay: assert property (s_wr_taken ##0 S_AXI_AWADDR == `SSR_OFF_IDHI |->
    ##2 S_AXI_BRESP == `SSR_RESP_OKAY)
    else $error("write to identification word not answered okay");
  a_status_flag_read: assert property (s_rd_taken(`SSR_OFF_STATUS) ##0 $past(WDOG_RST_CAUSE)
    |=> S_AXI_RDATA[`SSR_STS_WDOG_BIT])
    else $error("watchdog reset flag not seen in status");
  a_wdog_off_reset: assert property ($fell(SYS_RST) |-> !WDOG_RESET_REQ [*8])
    else $error("watchdog fired right after reset");
endmodule

`default_nettype wire

// File: tb/ssr_regs_bench.sv
// Self-checking bench for the status, scratch and identification register bank.
`timescale 1ns/10ps
`default_nettype none
`include "ssr_cfg.svh"

module ssr_regs_bench;
  localparam logic [31:0] ID_VAL = 32'h5a3c_7e19; // Arbitrary value.
  typedef struct {
    logic [7:0] addr;
    logic [31:0] wd;
    logic [31:0] rd;
    logic [1:0] resp;
  } ssr_row_type;
  logic core_clk, sys_rst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, wdog_cause, ext_cause, por_cause, wdog_req, irq;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd_v;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rsp_v;
  int bad_count, samples_checked;
  ssr_row_type rows [10];

  ssr_regs #(.ID_CODE(ID_VAL)) ssr_regs_inst (
    .CORE_CLK(core_clk), .SYS_RST(sys_rst),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .WDOG_RST_CAUSE(wdog_cause), .EXT_RST_CAUSE(ext_cause), .POR_RST_CAUSE(por_cause),
    .WDOG_RESET_REQ(wdog_req), .IRQ(irq)
  );

  always #10 core_clk = ~core_clk;

  // ---------------------------------------------------------------------------
  // Bus and check tasks
  // ---------------------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      bad_count++;
    end
  endtask

  // The address and data channels are released independently, as each is taken.
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_d, w_d, done;
    {aw_d, w_d, done} = '0;
    r = 2'b11;
    @(posedge core_clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    {awvalid, wvalid, bready} <= 3'h7;
    while (!done)
    begin
      @(posedge core_clk);
      if (!aw_d && awready)
      begin
        awvalid <= 1'b0;
        aw_d = 1'b1;
      end
      if (!w_d && wready)
      begin
        wvalid <= 1'b0;
        w_d = 1'b1;
      end
      if (bvalid)
      begin
        r = bresp;
        bready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_d, done;
    {ar_d, done} = '0;
    {d, r} = '1;
    @(posedge core_clk);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    while (!done)
    begin
      @(posedge core_clk);
      if (!ar_d && arready)
      begin
        arvalid <= 1'b0;
        ar_d = 1'b1;
      end
      if (rvalid)
      begin
        {d, r} = {rdata, rresp};
        rready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------------------
  initial
  begin
    {core_clk, awvalid, wvalid, bready, arvalid, rready} = '0;
    {wdog_cause, ext_cause, por_cause, awaddr, araddr, wdata, wstrb} = '0;
    sys_rst = 1'b1;
    {bad_count, samples_checked} = '0;
    rows = '{
      '{`SSR_OFF_STATUS, 32'h0000_0005, 32'h0000_0005, `SSR_RESP_OKAY},
      '{`SSR_OFF_SCRATCH0, 32'h0000_a501, 32'h0000_a501, `SSR_RESP_OKAY},
      '{`SSR_OFF_SCRATCH0 + 8'h04, 32'h0000_ffff, 32'h0000_ffff, `SSR_RESP_OKAY},
      '{`SSR_OFF_SCRATCH0 + 8'h08, 32'h0000_0000, 32'h0000_0000, `SSR_RESP_OKAY},
      '{`SSR_OFF_SCRATCH0 + 8'h0c, 32'h0000_5a0c, 32'h0000_5a0c, `SSR_RESP_OKAY},
      '{`SSR_OFF_SCRATCH0 + 8'h10, 32'h0000_8001, 32'h0000_8001, `SSR_RESP_OKAY},
      '{`SSR_OFF_IDHI, 32'h0000_ffff, {16'h0000, ID_VAL[31:16]}, `SSR_RESP_OKAY},
      '{`SSR_OFF_IDLO, 32'h0000_0000, {16'h0000, ID_VAL[15:0]}, `SSR_RESP_OKAY},
      '{8'h40, 32'h0000_1111, 32'h0000_0000, `SSR_RESP_SLVERR},
      '{8'hfc, 32'h0000_2222, 32'h0000_0000, `SSR_RESP_SLVERR}};
    repeat (10) @(posedge core_clk);
    sys_rst <= 1'b0;
    axi_rd(`SSR_OFF_WDCTL, rd_v, rsp_v);
    check("watchdog control", rd_v, 32'h0000_0000);
    check("irq", {31'h0, irq}, 32'h0000_0000);
    $display("test reset values done");
    // Every row is written before any is read back, so a write that leaks
    // into a neighbouring register shows up in the read pass.
    foreach (rows[i])
    begin
      axi_wr(rows[i].addr, rows[i].wd, rsp_v);
      check($sformatf("bresp %h", rows[i].addr), {30'h0, rsp_v}, {30'h0, rows[i].resp});
    end
    foreach (rows[i])
    begin
      axi_rd(rows[i].addr, rd_v, rsp_v);
      check($sformatf("rdata %h", rows[i].addr), rd_v, rows[i].rd);
      check($sformatf("rresp %h", rows[i].addr), {30'h0, rsp_v}, {30'h0, rows[i].resp});
    end
    $display("test table done");
    axi_wr(`SSR_OFF_WDCTL, 32'h0000_0001, rsp_v);
    {wdog_cause, ext_cause, por_cause} <= 3'h7;
    sys_rst <= 1'b1;
    repeat (10) @(posedge core_clk);
    sys_rst <= 1'b0;
    axi_rd(`SSR_OFF_WDCTL, rd_v, rsp_v);
    check("watchdog control", rd_v, 32'h0000_0000);
    axi_rd(`SSR_OFF_SCRATCH0, rd_v, rsp_v);
    check("scratch 0", rd_v, rows[1].rd);
    axi_rd(`SSR_OFF_STATUS, rd_v, rsp_v);
    check("status", rd_v, 32'h0000_0007);
    {wdog_cause, ext_cause, por_cause} <= 3'h0;
    axi_wr(`SSR_OFF_STATUS, 32'h0000_0000, rsp_v);
    axi_rd(`SSR_OFF_STATUS, rd_v, rsp_v);
    check("status", rd_v, 32'h0000_0000);
    $display("test second reset done");
    axi_rd(`SSR_OFF_IRQSTS, rd_v, rsp_v);
    axi_wr(`SSR_OFF_IRQMSK, 32'h0000_0004, rsp_v);
    axi_wr(`SSR_OFF_IDHI, 32'h0000_0001, rsp_v);
    repeat (2) @(posedge core_clk);
    check("irq masked", {31'h0, irq}, 32'h0000_0000);
    axi_rd(8'h40, rd_v, rsp_v);
    repeat (2) @(posedge core_clk);
    check("irq raised", {31'h0, irq}, 32'h0000_0001);
    axi_rd(`SSR_OFF_IRQSTS, rd_v, rsp_v);
    check("irq status", rd_v, 32'h0000_0006);
    repeat (2) @(posedge core_clk);
    check("irq cleared", {31'h0, irq}, 32'h0000_0000);
    $display("test interrupt done");
    // A slow master leaves both answers waiting; they must stand unchanged.
    {awaddr, araddr, wdata} <= {`SSR_OFF_SCRATCH0, `SSR_OFF_IDLO, 32'h0000_1234};
    {awvalid, wvalid, arvalid, bready, rready} <= 5'h1c;
    @(posedge core_clk) {awvalid, wvalid, arvalid} <= 3'h0;
    repeat (3) @(posedge core_clk);
    check("late answers", {30'h0, bvalid, rvalid}, 32'h0000_0003);
    check("late rdata", rdata, {16'h0000, ID_VAL[15:0]});
    {bready, rready} <= 2'h3;
    @(posedge core_clk) {bready, rready} <= 2'h0;
    $display("test late ready done");
    // A short timeout makes the watchdog expire a few cycles after it is enabled.
    axi_wr(`SSR_OFF_WDTO, 32'h0000_0004, rsp_v);
    axi_wr(`SSR_OFF_WDCTL, 32'h0000_0001, rsp_v);
    rd_v = '0;
    repeat (12) @(posedge core_clk) rd_v[0] |= wdog_req;
    check("watchdog pulse", rd_v, 32'h0000_0001);
    $display("test watchdog done");
    complete_run();
  end

  initial
  begin
    repeat (5000) @(posedge core_clk);
    bad_count++;
    complete_run();
  end
endmodule

bind ssr_regs ssr_regs_properties #(.ID_CODE(ID_CODE)) ssr_regs_properties_inst (
  .CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .S_AXI_AWADDR(S_AXI_AWADDR),
  .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID),
  .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID),
  .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID),
  .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RVALID(S_AXI_RVALID),
  .S_AXI_RREADY(S_AXI_RREADY), .WDOG_RST_CAUSE(WDOG_RST_CAUSE),
  .WDOG_RESET_REQ(WDOG_RESET_REQ)
);

`default_nettype wire
